/* verilog/ceiu_top.sv */
`timescale 1ns/1ps
`include "ceiu_params.svh"

module ceiu_top
  import ceiu_pkg::*;
#(
  parameter int NUM_CMP = `CEIU_MAX_CMP
)
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire ceiu_vec_t  cmp_level,
  output ceiu_vec_t       fabric_level,
  input  wire logic       reg_sel,
  input  wire logic       reg_wr,
  input  wire ceiu_word_t reg_addr,
  input  wire ceiu_word_t reg_wdata,
  output ceiu_word_t      reg_rdata,
  output logic            reg_ack,
  output ceiu_vec_t       irq_rise,
  output ceiu_vec_t       irq_fall
);

  localparam ceiu_vec_t IMPL =
    ceiu_vec_t'((32'h1 << NUM_CMP) - 32'h1);

  // address decode, shared by read and write paths
  function automatic ceiu_reg_e ceiu_decode(input ceiu_word_t addr);
    ceiu_reg_e r;
    r = CEIU_REG_NONE;
    case (addr)
      `CEIU_ADDR_LEVEL: r = CEIU_REG_LEVEL;
      `CEIU_ADDR_MASK:  r = CEIU_REG_MASK;
      `CEIU_ADDR_FLAGS: r = CEIU_REG_FLAGS;
      `CEIU_ADDR_CLEAR: r = CEIU_REG_CLEAR;
      default:          r = CEIU_REG_NONE;
    endcase
    return r;
  endfunction : ceiu_decode

  // rising bits to 21:12, falling bits to 9:0, rest zero
  function automatic ceiu_word_t ceiu_pack(input ceiu_vec_t rise,
                                           input ceiu_vec_t fall);
    ceiu_word_t w;
    w = `CEIU_RST_WORD;
    w[`CEIU_RISE_LSB +: `CEIU_MAX_CMP] = rise;
    w[`CEIU_FALL_LSB +: `CEIU_MAX_CMP] = fall;
    return w;
  endfunction : ceiu_pack

  ceiu_top_s st_ff;
  ceiu_top_s nxt_st;

  ceiu_vec_t lvl_sync;
  ceiu_vec_t rise_pulse;
  ceiu_vec_t fall_pulse;
  ceiu_vec_t set_rise;
  ceiu_vec_t set_fall;
  ceiu_vec_t clr_rise;
  ceiu_vec_t clr_fall;
  ceiu_reg_e acc_reg;
  logic      wr_mask;
  logic      wr_clear;
  logic      rd_req;

  assign fabric_level = cmp_level;

  ceiu_sync u_sync (
    .core_clk    (core_clk),
    .rst         (rst),
    .level_async (cmp_level),
    .level_sync  (lvl_sync)
  );

  ceiu_edge u_edge (
    .core_clk   (core_clk),
    .rst        (rst),
    .level      (lvl_sync),
    .rise_pulse (rise_pulse),
    .fall_pulse (fall_pulse)
  );

  assign acc_reg  = ceiu_decode(reg_addr);
  assign wr_mask  = reg_sel & reg_wr & (acc_reg == CEIU_REG_MASK);
  assign wr_clear = reg_sel & reg_wr & (acc_reg == CEIU_REG_CLEAR);
  assign rd_req   = reg_sel & ~reg_wr;

  assign set_rise = rise_pulse & IMPL;
  assign set_fall = fall_pulse & IMPL;

  // only ones in the clear word act
  assign clr_rise = wr_clear
    ? reg_wdata[`CEIU_RISE_LSB +: `CEIU_MAX_CMP] & IMPL
    : '0;
  assign clr_fall = wr_clear
    ? reg_wdata[`CEIU_FALL_LSB +: `CEIU_MAX_CMP] & IMPL
    : '0;

  always_comb begin
    nxt_st = st_ff;

    // sticky flags, set beats clear
    nxt_st.rise_flag = (st_ff.rise_flag & ~clr_rise) | set_rise;
    nxt_st.fall_flag = (st_ff.fall_flag & ~clr_fall) | set_fall;

    if (wr_mask) begin
      nxt_st.rise_en = reg_wdata[`CEIU_RISE_LSB +: `CEIU_MAX_CMP] & IMPL;
      nxt_st.fall_en = reg_wdata[`CEIU_FALL_LSB +: `CEIU_MAX_CMP] & IMPL;
    end

    // every access is answered on the next edge
    nxt_st.ack   = reg_sel;
    nxt_st.rdata = `CEIU_RST_WORD;
    // full 32-bit words here; the byte-wide neighbours use bits 7:0 only
    if (rd_req) begin
      unique case (acc_reg)
        CEIU_REG_LEVEL:
          nxt_st.rdata = ceiu_word_t'(lvl_sync & IMPL);
        CEIU_REG_MASK:
          nxt_st.rdata = ceiu_pack(st_ff.rise_en, st_ff.fall_en);
        CEIU_REG_FLAGS:
          nxt_st.rdata = ceiu_pack(st_ff.rise_flag, st_ff.fall_flag);
        CEIU_REG_CLEAR:
          nxt_st.rdata = `CEIU_RST_WORD;
        CEIU_REG_NONE:
          nxt_st.rdata = `CEIU_RST_WORD;
      endcase
    end

    if (rst) begin
      nxt_st.rise_flag = `CEIU_RST_VEC;
      nxt_st.fall_flag = `CEIU_RST_VEC;
      nxt_st.rise_en   = `CEIU_RST_VEC;
      nxt_st.fall_en   = `CEIU_RST_VEC;
      nxt_st.rdata     = `CEIU_RST_WORD;
      nxt_st.ack       = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  assign reg_rdata = st_ff.rdata;
  assign reg_ack   = st_ff.ack;

  // one line per event bit: falling lines 0-9, rising lines 0-9
  assign irq_rise = st_ff.rise_flag & st_ff.rise_en;
  assign irq_fall = st_ff.fall_flag & st_ff.fall_en;

  // checks

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (rst);

  sequence s_clear_write;
    reg_sel && reg_wr && (acc_reg == CEIU_REG_CLEAR);
  endsequence

  sequence s_read(ceiu_reg_e r);
    reg_sel && !reg_wr && (acc_reg == r);
  endsequence

  a_reset_zero: assert property (
    disable iff (1'b0)
    rst |=> (st_ff.rise_flag == '0) && (st_ff.fall_flag == '0)
            && (st_ff.rise_en == '0) && (st_ff.fall_en == '0)
            && (irq_rise == '0) && (irq_fall == '0))
    else $error("state not cleared by reset");

  a_flag_sticky: assert property (
    ##1 ((($past(st_ff.rise_flag) & ~$past(clr_rise))
          & ~st_ff.rise_flag) == '0)
        && ((($past(st_ff.fall_flag) & ~$past(clr_fall))
          & ~st_ff.fall_flag) == '0))
    else $error("event flag dropped without a clear");

  a_edge_sets: assert property (
    (|set_rise || |set_fall)
      |=> ((st_ff.rise_flag & $past(set_rise)) == $past(set_rise))
          && ((st_ff.fall_flag & $past(set_fall)) == $past(set_fall)))
    else $error("edge did not set its flag");

  a_clear_exact: assert property (
    (s_clear_write and (set_rise == '0) and (set_fall == '0))
      |=> ((st_ff.rise_flag
            & $past(reg_wdata[`CEIU_RISE_LSB +: `CEIU_MAX_CMP])) == '0)
          && ((st_ff.fall_flag
            & $past(reg_wdata[`CEIU_FALL_LSB +: `CEIU_MAX_CMP])) == '0))
    else $error("clear write left a flag set");

  a_clear_zero_keeps: assert property (
    s_clear_write
      |=> ((st_ff.rise_flag
            | $past(reg_wdata[`CEIU_RISE_LSB +: `CEIU_MAX_CMP]))
           & $past(st_ff.rise_flag)) == $past(st_ff.rise_flag))
    else $error("zero in clear word changed a flag");

  a_set_wins: assert property (
    (s_clear_write and (|(clr_rise & set_rise) || |(clr_fall & set_fall)))
      |=> (((st_ff.rise_flag & $past(clr_rise & set_rise))
             == $past(clr_rise & set_rise))
          && ((st_ff.fall_flag & $past(clr_fall & set_fall))
             == $past(clr_fall & set_fall))))
    else $error("clear beat a simultaneous edge");

  a_mask_gates: assert property (
    (wr_mask && (reg_wdata == '0))
      |=> ((irq_rise == '0) && (irq_fall == '0)) [*2])
    else $error("masked flag reached an interrupt line");

  a_irq_follow: assert property (
    (wr_mask && (reg_wdata == 32'hFFFFFFFF) && !wr_clear)
      |=> (irq_rise == st_ff.rise_flag) && (irq_fall == st_ff.fall_flag))
    else $error("enabled flag missing on interrupt line");

  a_level_read: assert property (
    s_read(CEIU_REG_LEVEL)
      |=> reg_ack && (reg_rdata == ceiu_word_t'($past(lvl_sync) & IMPL)))
    else $error("level read returned wrong value");

  a_clear_read: assert property (
    (s_read(CEIU_REG_CLEAR) or s_read(CEIU_REG_NONE))
      |=> reg_ack && (reg_rdata == '0))
    else $error("write-only or unmapped read not zero");

  a_reserved_zero: assert property (
    reg_ack |-> (reg_rdata[31:22] == '0) && (reg_rdata[11:10] == '0))
    else $error("reserved bits read nonzero");

  a_flag_read: assert property (
    s_read(CEIU_REG_FLAGS)
      |=> reg_rdata == ceiu_pack($past(st_ff.rise_flag),
                                 $past(st_ff.fall_flag)))
    else $error("flag read layout wrong");

  a_sync_delay: assert property (
    $rose(cmp_level[0]) ##1 cmp_level[0] [*2]
      |-> lvl_sync[0])
    else $error("level not through synchroniser in two cycles");

  a_ack_timing: assert property (
    reg_sel |=> reg_ack ##0 ($past(reg_sel) == 1'b1))
    else $error("access not acknowledged next cycle");

  a_ack_single: assert property (
    !reg_sel |=> !reg_ack)
    else $error("acknowledge without a request");

  a_rdata_idle: assert property (
    !rd_req |=> (reg_rdata == '0))
    else $error("read data not zero outside a read");

  a_reset_outputs: assert property (
    disable iff (1'b0)
    rst |=> !reg_ack && (reg_rdata == '0))
    else $error("bus outputs not cleared by reset");

  a_no_reset_edge: assert property (
    disable iff (1'b0)
    rst |=> (rise_pulse == '0) && (fall_pulse == '0))
    else $error("edge reported straight after reset");

  a_fabric_copy: assert property (
    fabric_level == cmp_level)
    else $error("fabric level differs from comparator level");

  a_level_reserved: assert property (
    s_read(CEIU_REG_LEVEL)
      |=> (reg_rdata[31:`CEIU_MAX_CMP] == '0))
    else $error("reserved level bits read nonzero");

  a_unimpl_zero: assert property (
    ((st_ff.rise_flag & ~IMPL) == '0) && ((st_ff.fall_flag & ~IMPL) == '0)
    && ((st_ff.rise_en & ~IMPL) == '0) && ((st_ff.fall_en & ~IMPL) == '0))
    else $error("state set beyond the fitted comparators");

  a_new_flag: assert property (
    ##1 ((st_ff.rise_flag & ~$past(st_ff.rise_flag)
          & ~$past(set_rise)) == '0)
        && ((st_ff.fall_flag & ~$past(st_ff.fall_flag)
          & ~$past(set_fall)) == '0))
    else $error("event flag set without an edge");

  a_mask_write: assert property (
    wr_mask
      |=> (st_ff.rise_en
           == ($past(reg_wdata[`CEIU_RISE_LSB +: `CEIU_MAX_CMP]) & IMPL))
          && (st_ff.fall_en
           == ($past(reg_wdata[`CEIU_FALL_LSB +: `CEIU_MAX_CMP]) & IMPL)))
    else $error("enable write did not land");

  a_mask_hold: assert property (
    !wr_mask |=> $stable(st_ff.rise_en) && $stable(st_ff.fall_en))
    else $error("enable changed without a write");

  a_flag_unmasked: assert property (
    (wr_mask && (set_rise == '0) && (set_fall == '0))
      |=> $stable(st_ff.rise_flag) && $stable(st_ff.fall_flag))
    else $error("enable write disturbed an event flag");

  a_irq_masked: assert property (
    ((st_ff.rise_en == '0) && (st_ff.fall_en == '0))
      |-> (irq_rise == '0) && (irq_fall == '0))
    else $error("interrupt line active while masked");

  a_ro_write: assert property (
    (reg_sel && reg_wr && (acc_reg != CEIU_REG_CLEAR)
     && (set_rise == '0) && (set_fall == '0))
      |=> $stable(st_ff.rise_flag) && $stable(st_ff.fall_flag))
    else $error("write to another register changed a flag");

  a_clear_acked: assert property (
    s_clear_write |=> reg_ack && (reg_rdata == '0))
    else $error("clear write not acknowledged");

  a_clear_fall_keeps: assert property (
    s_clear_write
      |=> ((st_ff.fall_flag
            | $past(reg_wdata[`CEIU_FALL_LSB +: `CEIU_MAX_CMP]))
           & $past(st_ff.fall_flag)) == $past(st_ff.fall_flag))
    else $error("zero in clear word changed a falling flag");

  a_mask_read: assert property (
    s_read(CEIU_REG_MASK)
      |=> reg_rdata == ceiu_pack($past(st_ff.rise_en),
                                 $past(st_ff.fall_en)))
    else $error("enable read layout wrong");

  a_sync_fall: assert property (
    $fell(cmp_level[0]) ##1 !cmp_level[0] [*2]
      |-> !lvl_sync[0])
    else $error("low level not through synchroniser in two cycles");

  c_rise_irq: cover property (
    (|set_rise) ##1 (|irq_rise));

  c_set_clear_clash: cover property (
    s_clear_write and (|(clr_rise & set_rise)));

  c_clear_flag: cover property (
    (|st_ff.rise_flag) ##0 s_clear_write ##1 (st_ff.rise_flag == '0));

  c_level_read: cover property (
    s_read(CEIU_REG_LEVEL) ##1 (reg_rdata != '0));

  c_fall_irq: cover property (
    (|set_fall) ##1 (|irq_fall));

endmodule : ceiu_top

/* include/ceiu_params.svh */
`ifndef CEIU_PARAMS_SVH
`define CEIU_PARAMS_SVH

`define CEIU_ADDR_LEVEL  32'h4002100C
`define CEIU_ADDR_MASK   32'h4002120C
`define CEIU_ADDR_FLAGS  32'h40021210
`define CEIU_ADDR_CLEAR  32'h40021214

`define CEIU_MAX_CMP     10
`define CEIU_RISE_LSB    12
`define CEIU_FALL_LSB    0
`define CEIU_CFG_BYTE_W  8

`define CEIU_RST_LEVEL   10'h000
`define CEIU_RST_VEC     10'h000
`define CEIU_RST_WORD    32'h00000000

`endif

/* include/ceiu_pkg.sv */
`include "ceiu_params.svh"

package ceiu_pkg;

  typedef logic [`CEIU_MAX_CMP-1:0] ceiu_vec_t;
  typedef logic [31:0]              ceiu_word_t;

  typedef enum logic [2:0] {
    CEIU_REG_NONE,
    CEIU_REG_LEVEL,
    CEIU_REG_MASK,
    CEIU_REG_FLAGS,
    CEIU_REG_CLEAR
  } ceiu_reg_e;

  typedef struct packed {
    ceiu_vec_t stage1;
    ceiu_vec_t stage2;
  } ceiu_sync_s;

  typedef struct packed {
    ceiu_vec_t prev;
    logic      armed;
  } ceiu_edge_s;

  typedef struct packed {
    ceiu_vec_t  rise_flag;
    ceiu_vec_t  fall_flag;
    ceiu_vec_t  rise_en;
    ceiu_vec_t  fall_en;
    ceiu_word_t rdata;
    logic       ack;
  } ceiu_top_s;

endpackage : ceiu_pkg

/* verilog/ceiu_sync.sv */
`timescale 1ns/1ps
`include "ceiu_params.svh"

module ceiu_sync
  import ceiu_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire ceiu_vec_t level_async,
  output ceiu_vec_t      level_sync
);

  ceiu_sync_s st_ff;
  ceiu_sync_s nxt_st;

  // two flops per comparator; stage1 only feeds stage2
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.stage1 = level_async;
    nxt_st.stage2 = st_ff.stage1;
    if (rst) begin
      nxt_st.stage1 = `CEIU_RST_LEVEL;
      nxt_st.stage2 = `CEIU_RST_LEVEL;
    end
  end

  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  assign level_sync = st_ff.stage2;

endmodule : ceiu_sync

/* verilog/ceiu_edge.sv */
`timescale 1ns/1ps
`include "ceiu_params.svh"

module ceiu_edge
  import ceiu_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire ceiu_vec_t level,
  output ceiu_vec_t      rise_pulse,
  output ceiu_vec_t      fall_pulse
);

  ceiu_edge_s st_ff;
  ceiu_edge_s nxt_st;

  // first cycle after reset only learns the level, no false edge
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.prev  = level;
    nxt_st.armed = 1'b1;
    if (rst) begin
      nxt_st.prev  = `CEIU_RST_VEC;
      nxt_st.armed = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  assign rise_pulse = st_ff.armed ? (level & ~st_ff.prev) : '0;
  assign fall_pulse = st_ff.armed ? (~level & st_ff.prev) : '0;

  a_edge_once: assert property (
    @(posedge core_clk) disable iff (rst)
    (|rise_pulse) |=> ((rise_pulse & $past(rise_pulse)) == '0))
    else $error("rising edge pulsed twice in a row");

endmodule : ceiu_edge

/* bench/ceiu_irq_model.sv */
`timescale 1ns/1ps
`include "ceiu_params.svh"

module ceiu_irq_model
  import ceiu_pkg::*;
(
  input  wire ceiu_vec_t irq_rise,
  input  wire ceiu_vec_t irq_fall,
  output logic [106:85]  irq_line
);
  // controller view: falling lines first, two unused, then rising lines
  always_comb begin
    irq_line         = '0;
    irq_line[94:85]  = irq_fall;
    irq_line[106:97] = irq_rise;
  end
endmodule : ceiu_irq_model

/* bench/tb_comparator_edge_irq_unit.sv */
`timescale 1ns/1ps
`include "ceiu_params.svh"

module tb_comparator_edge_irq_unit
  import ceiu_pkg::*;
;
  localparam ceiu_word_t VALID = 32'h003FF3FF;
  localparam ceiu_word_t UNMAP = 32'h40021218;
  logic          core_clk    = 1'b0;
  logic          rst         = 1'b1;
  ceiu_vec_t     cmp_level   = '0;
  logic          reg_sel     = 1'b0;
  logic          reg_wr      = 1'b0;
  ceiu_word_t    reg_addr    = '0;
  ceiu_word_t    reg_wdata   = '0;
  ceiu_vec_t     fabric_level;
  ceiu_word_t    reg_rdata;
  logic          reg_ack;
  ceiu_vec_t     irq_rise;
  ceiu_vec_t     irq_fall;
  logic [106:85] irq_line;
  int            miscompares = 0;
  int            checked     = 0;
  integer        seed        = 32'hAF91;
  ceiu_vec_t     rise_f      = '0;
  ceiu_vec_t     fall_f      = '0;
  ceiu_word_t    en          = '0;
  ceiu_word_t    w;
  logic          seen;

  ceiu_top #(.NUM_CMP(10)) ceiu_top_i (
    .core_clk     (core_clk),
    .rst          (rst),
    .cmp_level    (cmp_level),
    .fabric_level (fabric_level),
    .reg_sel      (reg_sel),
    .reg_wr       (reg_wr),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_rdata    (reg_rdata),
    .reg_ack      (reg_ack),
    .irq_rise     (irq_rise),
    .irq_fall     (irq_fall)
  );

  ceiu_irq_model ceiu_irq_model_i (
    .irq_rise (irq_rise),
    .irq_fall (irq_fall),
    .irq_line (irq_line)
  );

  always #5 core_clk = ~core_clk;

  task automatic results;
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input ceiu_word_t seen_v, input ceiu_word_t exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : chk

  function automatic ceiu_word_t flag_word(input ceiu_vec_t r,
                                           input ceiu_vec_t f);
    return {10'h000, r, 2'b00, f};
  endfunction : flag_word

  // one access: request held one cycle, answer taken after the next edge
  task automatic acc(input logic wr_v, input ceiu_word_t a,
                     input ceiu_word_t d, output ceiu_word_t rdat);
    @(posedge core_clk) #1;
    reg_sel   = 1'b1;
    reg_wr    = wr_v;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge core_clk) #1;
    reg_sel = 1'b0;
    rdat    = reg_rdata;
    chk(32'(reg_ack), 32'h1);
  endtask : acc

  task automatic rd(input ceiu_word_t a, input ceiu_word_t e);
    ceiu_word_t r;
    acc(1'b0, a, '0, r);
    chk(r, e);
  endtask : rd

  task automatic wr(input ceiu_word_t a, input ceiu_word_t d);
    ceiu_word_t r;
    acc(1'b1, a, d, r);
  endtask : wr

  // new comparator levels, with the flags they must raise
  task automatic drive_level(input ceiu_vec_t v);
    @(posedge core_clk) #1;
    rise_f    |= v & ~cmp_level;
    fall_f    |= cmp_level & ~v;
    cmp_level  = v;
    repeat (5) @(posedge core_clk);
    #1;
  endtask : drive_level

  task automatic check_all;
    chk(32'(fabric_level), 32'(cmp_level));
    rd(`CEIU_ADDR_LEVEL, 32'(cmp_level));
    rd(`CEIU_ADDR_FLAGS, flag_word(rise_f, fall_f));
    rd(`CEIU_ADDR_MASK, en);
    chk(32'(irq_line), flag_word(rise_f, fall_f) & en);
  endtask : check_all

  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check_all;
    rd(`CEIU_ADDR_CLEAR, '0);
    rd(UNMAP, '0);
    wr(`CEIU_ADDR_FLAGS, 32'hFFFFFFFF);
    wr(`CEIU_ADDR_LEVEL, 32'hFFFFFFFF);
    wr(UNMAP, 32'hFFFFFFFF);
    check_all;
    for (int i = 0; i < 40; i++) begin
      w = $random(seed);
      if (i == 0) begin
        w = '1;
      end
      if (i == 1) begin
        w = '0;
      end
      drive_level(w[9:0]);
      if (i % 3 == 0) begin
        w = $random(seed);
        if (i == 3) begin
          w = '0;
        end
        wr(`CEIU_ADDR_MASK, w);
        en = w & VALID;
      end
      check_all;
      w = $random(seed);
      wr(`CEIU_ADDR_CLEAR, w);
      rise_f &= ~w[21:12];
      fall_f &= ~w[9:0];
      check_all;
    end
    // clears every cycle while comparator 0 rises: set must win once
    drive_level('0);
    wr(`CEIU_ADDR_MASK, 32'hFFFFFFFF);
    en = VALID;
    wr(`CEIU_ADDR_CLEAR, 32'hFFFFFFFF);
    rise_f = '0;
    fall_f = '0;
    seen   = 1'b0;
    @(posedge core_clk) #1;
    cmp_level = 10'h001;
    reg_sel   = 1'b1;
    reg_wr    = 1'b1;
    reg_addr  = `CEIU_ADDR_CLEAR;
    reg_wdata = 32'h00001000;
    repeat (8) begin
      @(posedge core_clk) #1;
      seen |= irq_rise[0];
    end
    reg_sel = 1'b0;
    chk(32'(seen), 32'h1);
    check_all;
    results;
  end

  initial begin
    #100000;
    miscompares++;
    results;
  end
endmodule : tb_comparator_edge_irq_unit
